// ===== bench/rcr_regulator_config_bench.sv
// Self-checking bench for the regulator config registers
`timescale 1ns/1ps
module rcr_regulator_config_bench;
    import rcr_pkg::*;
    logic clk, rst_n, reg_wr, wr_open, reg_rd, rv0;
    logic [7:0] reg_addr, reg_wdata, rd0, rd1, v0, v1;
    logic [5:0] fc, vc;
    logic fe, fl, ve, vl, ve1;
    int n_errors, n_checks, cyc;
    // ==========================================================
    // Locked-ceiling part and open-ceiling part side by side
    rcr_regulator_config #(.VARIANT(0)) u_rcr_regulator_config (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rd0),
        .reg_rvalid(rv0), .four_code(fc), .four_enable(fe),
        .four_low_power(fl), .five_code(vc), .five_enable(ve),
        .five_low_power(vl));
    rcr_regulator_config #(.VARIANT(3)) u_rcr_regulator_config_open (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(wr_open),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rd1),
        .reg_rvalid(), .four_code(), .four_enable(),
        .four_low_power(), .five_code(), .five_enable(ve1),
        .five_low_power());
    // ==========================================================
    // Shared tasks
    task automatic chk(input string s, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", s, exp, seen);
        end
    endtask
    // Separate strobes keep the two parts' histories apart
    task automatic wr(input logic [7:0] a, d, input logic b);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        if (b) wr_open <= 1'b1;
        else reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        wr_open <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        // Valid stands only in the cycle after the strobe is taken
        #1;
        chk("rvalid", {7'h00, rv0}, 8'h01);
        v0 = rd0;
        v1 = rd1;
    endtask
    // Regulator outputs lag the register by one cycle
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_defaults();
        rd(FOUR_NORMAL_OFS);
        chk("normal", v0, FOUR_NORMAL_RST[0]);
        chk("normal_open", v1, FOUR_NORMAL_RST[3]);
        rd(FOUR_SCALING_OFS);
        chk("scaling", v0, FOUR_SCALING_RST[0]);
        chk("scaling_open", v1, FOUR_SCALING_RST[3]);
        rd(FOUR_CEILING_OFS);
        chk("ceiling", v0, FOUR_CEILING_RST[0]);
        chk("ceiling_open", v1, FOUR_CEILING_RST[3]);
        rd(FIVE_CONTROL_OFS);
        chk("five", v0, FIVE_CONTROL_RST[0]);
        chk("five_open", v1, FIVE_CONTROL_RST[3]);
        chk("four_out", {fe, fl, fc},
            {FOUR_SCALING_RST[0][7:6], FOUR_NORMAL_RST[0][5:0]});
        chk("five_out", {ve, vl, vc}, FIVE_CONTROL_RST[0]);
        chk("five_on_open", {7'h00, ve1},
            {7'h00, FIVE_CONTROL_RST[3][ENABLE_BIT]});
    endtask
    task automatic t_locked();
        wr(FOUR_CEILING_OFS, 8'h3F, 1'b0);
        wr(FOUR_CEILING_OFS, 8'h00, 1'b0);
        rd(FOUR_CEILING_OFS);
        chk("ceiling_locked", v0, 8'h28);
        wr(FOUR_NORMAL_OFS, 8'h0A, 1'b0);
        rd(FOUR_NORMAL_OFS);
        chk("normal_over", v0, 8'h24);
        wr(FOUR_NORMAL_OFS, 8'h08, 1'b0);
        rd(FOUR_NORMAL_OFS);
        chk("normal_at", v0, 8'h28);
        wr(FOUR_SCALING_OFS, 8'h09, 1'b0);
        rd(FOUR_SCALING_OFS);
        chk("scaling_over", v0, 8'h22);
        wr(FOUR_SCALING_OFS, 8'hC8, 1'b0);
        wr(FOUR_NORMAL_OFS, 8'h47, 1'b0);
        settle();
        chk("four_scaling", {fe, fl, fc}, 8'hE8);
        wr(FOUR_NORMAL_OFS, 8'h05, 1'b0);
        settle();
        chk("four_normal", {fe, fl, fc}, 8'hE5);
    endtask
    task automatic t_five();
        logic [7:0] d [4];
        d = '{8'h80, 8'h40, 8'h1F, 8'h00};
        foreach (d[i])
        begin
            wr(FIVE_CONTROL_OFS, d[i], 1'b0);
            settle();
            chk("five_out", {ve, vl, vc}, d[i] | 8'h20);
            rd(FIVE_CONTROL_OFS);
            chk("five_reg", v0, d[i] | 8'h20);
        end
    endtask
    task automatic t_open();
        wr(FOUR_CEILING_OFS, 8'hFF, 1'b1);
        rd(FOUR_CEILING_OFS);
        chk("ceiling_top", v1, 8'h3F);
        wr(FOUR_CEILING_OFS, 8'h30, 1'b1);
        wr(FOUR_CEILING_OFS, 8'h3F, 1'b1);
        rd(FOUR_CEILING_OFS);
        chk("ceiling_self_lock", v1, 8'h30);
        wr(FOUR_NORMAL_OFS, 8'h11, 1'b1);
        rd(FOUR_NORMAL_OFS);
        chk("open_over", v1, 8'h25);
    endtask
    // ==========================================================
    // Run control
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole run needs under a hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            finish_test();
        end
    end
    initial
    begin
        {rst_n, reg_wr, wr_open, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults();
        t_locked();
        t_five();
        t_open();
        finish_test();
    end
endmodule // rcr_regulator_config_bench

// ===== hdl/rcr_ceiling_check.sv
// Ceiling comparison for the fourth regulator voltage codes
`timescale 1ns/1ps
module rcr_ceiling_check
(
    // Code under test
    input wire logic [5:0] code,
    // Current ceiling
    input wire logic [5:0] ceiling,
    // Result
    output logic code_ok
);
    // ==========================================================
    // Compare
    // reject codes above ceiling
    // The stored code always carries a forced top bit, so compare that
    // All-zero ceiling is treated as unprogrammed, not as a 0 V clamp
    assign code_ok = (ceiling == 6'h00) || ({1'b1, code[4:0]} <= ceiling);
endmodule // rcr_ceiling_check

// ===== hdl/rcr_regulator_config.sv
// Configuration registers for the fourth and fifth linear regulators
`timescale 1ns/1ps

module rcr_regulator_config
#(
    parameter int VARIANT = 0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port from the serial control interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Fourth regulator controls
    output logic [5:0] four_code,
    output logic four_enable,
    output logic four_low_power,
    // Fifth regulator controls
    output logic [5:0] five_code,
    output logic five_enable,
    output logic five_low_power
);
    import rcr_pkg::*;

    // ==========================================================
    // Register state
    logic [7:0] normal_reg;
    logic [7:0] scaling_reg;
    logic [5:0] ceiling_reg;
    logic [7:0] five_reg;
    logic [7:0] next_normal_reg;
    logic [7:0] next_scaling_reg;
    logic [5:0] next_ceiling_reg;
    logic [7:0] next_five_reg;
    logic code_ok;
    logic ceiling_locked;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic [7:0] fix_top(input logic [7:0] v);
        return {v[7:6], 1'b1, v[4:0]};
    endfunction

    rcr_ceiling_check u_check
    (
        .code(reg_wdata[5:0]),
        .ceiling(ceiling_reg),
        .code_ok(code_ok)
    );

    assign ceiling_locked = (ceiling_reg != CEIL_OPEN_LOW) &&
        (ceiling_reg != CEIL_OPEN_HIGH);

    always_comb
    begin
        next_normal_reg = normal_reg;
        next_scaling_reg = scaling_reg;
        next_ceiling_reg = ceiling_reg;
        next_five_reg = five_reg;
        if (reg_wr)
        begin
            if (hit(reg_addr, FOUR_NORMAL_OFS) && code_ok)
            begin
                next_normal_reg = fix_top(reg_wdata);
            end
            if (hit(reg_addr, FOUR_SCALING_OFS) && code_ok)
            begin
                next_scaling_reg = fix_top(reg_wdata);
            end
            if (hit(reg_addr, FOUR_CEILING_OFS) && !ceiling_locked)
            begin
                next_ceiling_reg = reg_wdata[5:0];
            end
            if (hit(reg_addr, FIVE_CONTROL_OFS))
            begin
                next_five_reg = fix_top(reg_wdata);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            normal_reg <= FOUR_NORMAL_RST[VARIANT];
            scaling_reg <= FOUR_SCALING_RST[VARIANT];
            ceiling_reg <= FOUR_CEILING_RST[VARIANT][5:0];
            five_reg <= FIVE_CONTROL_RST[VARIANT];
        end
        else
        begin
            normal_reg <= next_normal_reg;
            scaling_reg <= next_scaling_reg;
            ceiling_reg <= next_ceiling_reg;
            five_reg <= next_five_reg;
        end
    end

    // ==========================================================
    // Read-back and regulator outputs
    logic [7:0] next_reg_rdata;
    logic [5:0] next_four_code;

    always_comb
    begin
        next_reg_rdata = UNMAPPED_DATA;
        if (hit(reg_addr, FOUR_NORMAL_OFS))
        begin
            next_reg_rdata = normal_reg;
        end
        else if (hit(reg_addr, FOUR_SCALING_OFS))
        begin
            next_reg_rdata = scaling_reg;
        end
        else if (hit(reg_addr, FOUR_CEILING_OFS))
        begin
            next_reg_rdata = {2'b00, ceiling_reg};
        end
        else if (hit(reg_addr, FIVE_CONTROL_OFS))
        begin
            next_reg_rdata = five_reg;
        end
        next_four_code = normal_reg[SOURCE_SEL_BIT] ?
            scaling_reg[5:0] : normal_reg[5:0];
    end

    // Outputs lag the registers by one cycle so every pin is a flop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            four_code <= 6'h00;
            four_enable <= 1'b0;
            four_low_power <= 1'b0;
            five_code <= 6'h20;
            five_enable <= 1'b0;
            five_low_power <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? next_reg_rdata : reg_rdata;
            reg_rvalid <= reg_rd;
            four_code <= next_four_code;
            four_enable <= scaling_reg[ENABLE_BIT];
            four_low_power <= scaling_reg[LOW_POWER_BIT];
            five_code <= five_reg[5:0];
            five_enable <= five_reg[ENABLE_BIT];
            five_low_power <= five_reg[LOW_POWER_BIT];
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_normal_reject: assert property (
        reg_wr && hit(reg_addr, FOUR_NORMAL_OFS) && !code_ok
        |=> normal_reg == $past(normal_reg))
        else $error("normal code changed by rejected write");
    chk_scaling_reject: assert property (
        reg_wr && hit(reg_addr, FOUR_SCALING_OFS) && !code_ok
        |=> scaling_reg == $past(scaling_reg))
        else $error("scaling code changed by rejected write");
    chk_normal_accept: assert property (
        reg_wr && hit(reg_addr, FOUR_NORMAL_OFS) && code_ok
        |=> normal_reg[4:0] == $past(reg_wdata[4:0]))
        else $error("accepted normal code not stored");
    chk_ceiling_lock: assert property (
        ceiling_locked |=> ceiling_reg == $past(ceiling_reg))
        else $error("locked ceiling changed");
    chk_five_top_bit: assert property (
        reg_wr && hit(reg_addr, FIVE_CONTROL_OFS)
        |=> ##1 five_code[CODE_MSB] && five_code[4:0] == $past(reg_wdata[4:0], 2))
        else $error("fifth code top bit not fixed");
    // Outputs hold reset values one edge past release, so start after it
    chk_five_enable: assert property (
        rst_n |=> five_enable == $past(five_reg[ENABLE_BIT]))
        else $error("fifth enable does not follow register");
    chk_five_save: assert property (
        rst_n |=> five_low_power == $past(five_reg[LOW_POWER_BIT]))
        else $error("fifth power save does not follow register");
    chk_source_select: assert property (
        rst_n |=> four_code == ($past(normal_reg[SOURCE_SEL_BIT]) ?
        $past(scaling_reg[5:0]) : $past(normal_reg[5:0])))
        else $error("fourth code from wrong source");
    chk_unused_zero: assert property (
        reg_rd && hit(reg_addr, FOUR_CEILING_OFS)
        |=> reg_rvalid && reg_rdata[7:6] == 2'b00)
        else $error("ceiling unused bits not zero");
    chk_five_range: assert property (
        five_code >= 6'h20)
        else $error("fifth code below upper range");

    cov_reject: cover property (reg_wr && !code_ok &&
        hit(reg_addr, FOUR_NORMAL_OFS));
    cov_lock: cover property (!ceiling_locked ##1 ceiling_locked);
    cov_scaling_sel: cover property (normal_reg[SOURCE_SEL_BIT]);
    cov_five_on: cover property ($rose(five_enable));
endmodule // rcr_regulator_config

// ===== pkg/rcr_pkg.sv
// Register map, field layout and reset defaults of the regulator config bank
package rcr_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] FOUR_NORMAL_OFS = 8'h19;
    localparam logic [7:0] FOUR_SCALING_OFS = 8'h1A;
    localparam logic [7:0] FOUR_CEILING_OFS = 8'h1B;
    localparam logic [7:0] FIVE_CONTROL_OFS = 8'h1C;

    // ==========================================================
    // Field positions
    localparam int ENABLE_BIT = 7;
    localparam int LOW_POWER_BIT = 6;
    localparam int SOURCE_SEL_BIT = 6;
    localparam int CODE_MSB = 5;
    localparam int CODE_W = 6;

    // ==========================================================
    // Ceiling values that keep the ceiling register writable, and read data for unmapped offsets
    localparam logic [5:0] CEIL_OPEN_LOW = 6'h00;
    localparam logic [5:0] CEIL_OPEN_HIGH = 6'h3F;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // ==========================================================
    // One-time-programmed defaults, one entry per part variant
    localparam int VARIANTS = 4;
    typedef logic [7:0] rcr_byte_type;
    localparam rcr_byte_type FOUR_NORMAL_RST [VARIANTS] =
        '{8'h24, 8'h24, 8'h38, 8'h25};
    localparam rcr_byte_type FOUR_SCALING_RST [VARIANTS] =
        '{8'h22, 8'h22, 8'hB8, 8'hA5};
    localparam rcr_byte_type FOUR_CEILING_RST [VARIANTS] =
        '{8'h28, 8'h28, 8'h3D, 8'h3F};
    localparam rcr_byte_type FIVE_CONTROL_RST [VARIANTS] =
        '{8'h36, 8'h36, 8'h38, 8'hA5};

endpackage
